// ---- bench/dac_digital_datapath_control_tb.sv ----
// Purpose: self-checking bench for both ends of the control link
// Assumes: one hclk feeds both ends, AHB-Lite master lives here
// Notes:   stale pairs are skipped after every mode change
`timescale 1ns/10ps
`default_nettype none
module dac_digital_datapath_control_tb;
  // ==========================================================
  // signals
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        out_valid;
  logic [15:0] out_i;
  logic [15:0] out_q;
  wire logic [8:0] levels; // several ports drive its bits
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;
  integer      seed = 92215;
  logic [31:0] rd;
  logic [15:0] v;
  logic [15:0] wi;
  logic [15:0] wq;
  logic [4:0]  md;
  ddc_link_if  link_if ();
  // ==========================================================
  // both ends and the checker
  ddc_device ddc_device_inst (.hclk(hclk), .hresetn(hresetn),
    .link(link_if.device), .out_valid(out_valid), .out_i(out_i),
    .out_q(out_q), .nco_accum_clear(levels[8]),
    .pseudorandom_align_on(levels[7]), .align_method_pn(levels[6]),
    .pulse_align_on(levels[5]), .inv_sinc_on(levels[4]),
    .interp_rate(levels[3:2]), .real_only(levels[1]),
    .mod_half_gain(levels[0]));
  ddc_host ddc_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .link(link_if.host));
  ddc_properties ddc_properties_inst (.hclk(hclk), .hresetn(hresetn),
    .reg_wr(link_if.reg_wr), .reg_addr(link_if.reg_addr),
    .reg_wdata(link_if.reg_wdata), .reg_rdata(link_if.reg_rdata),
    .soft_reset(link_if.soft_reset), .sclk_out(link_if.sclk_out),
    .sclk_oe(link_if.sclk_oe), .sclk_pin(link_if.sclk_pin));
  // ==========================================================
  // clock and hang guard, generous against about 800 cycles used
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end
  // ==========================================================
  // helpers
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one single transfer; held until hready is seen high
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0); // response must be OKAY
  endtask
  // bounded by the hang guard only
  task automatic wait_pair();
    @(posedge hclk);
    while (out_valid !== 1'b1) @(posedge hclk);
  endtask
  function automatic logic [8:0] exp_lv(input logic [15:0] c);
    return {c[14], c[13], c[12], c[11], c[9], c[7:6], c[3], c[0]};
  endfunction
  // offset binary differs from two's complement in the sign bit
  function automatic logic [31:0] exp_pair(input logic [15:0] i, q,
                                           input logic f, r);
    return {i ^ {f, 15'h0}, r ? 16'h0000 : q ^ {f, 15'h0}};
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(32'h0C, 1'b0, 32'h0);
    check(rd, {16'h0, ddc_pkg::DDC_CTRL_RESET});
    for (int k = 0; k < 10; k++) begin
      v = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($random(seed));
      v[7:6] = 2'(k);
      xfer(32'h0C, 1'b1, {16'h0, v});
      xfer(32'h0C, 1'b0, 32'h0);
      check(rd, {16'h0, v & 16'h7BFF});
      check({23'h0, levels}, {23'h0, exp_lv(v)});
    end
    xfer(32'h20, 1'b1, 32'hFFFFFFFF);
    xfer(32'h20, 1'b0, 32'h0);
    check(rd, 32'h0);
    xfer(32'h00, 1'b1, 32'h8);
    xfer(32'h0C, 1'b1, 32'hFFFF);
    xfer(32'h0C, 1'b0, 32'h0);
    check(rd, 32'h0100);
    xfer(32'h00, 1'b1, 32'h0);
    xfer(32'h0C, 1'b0, 32'h0);
    check(rd, 32'h0100);
    // clock pin off: the source must send nothing
    xfer(32'h0C, 1'b1, 32'h0);
    xfer(32'h00, 1'b1, 32'h1);
    xfer(32'h10, 1'b0, 32'h0);
    v = rd[31:16];
    repeat (60) @(posedge hclk);
    xfer(32'h10, 1'b0, 32'h0);
    check({16'h0, rd[31:16]}, {16'h0, v});
    // md: fmt, single, real, swap, q first
    for (int m = 0; m < 8; m++) begin
      md = {m[0] ^ m[2], m[0], m[1] ^ m[0], m[1], m[2]};
      wi = 16'($random(seed));
      wq = 16'($random(seed));
      xfer(32'h04, 1'b1, {16'h0, wi});
      xfer(32'h08, 1'b1, {16'h0, wq});
      xfer(32'h0C, 1'b1, {16'h0, 16'h0100 | {10'h0, md, 1'b0}});
      xfer(32'h00, 1'b1, {29'h0, md[1], md[3], 1'b1});
      repeat (4) wait_pair();
      for (int p = 0; p < 2; p++) begin
        wait_pair();
        check({out_i, out_q}, exp_pair(wi, wq, md[4], md[2]));
      end
    end
    // second reset in mid-stream
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(32'h0C, 1'b0, 32'h0);
    check(rd, 32'h0100);
    stop_test();
  end
endmodule
`default_nettype wire

// ---- bench/ddc_properties.sv ----
// Purpose: link properties between source end and converter end
// Assumes: one hclk domain, host always addresses offset 0x01
// Notes:   watches interface signals only, no bind
`timescale 1ns/10ps
`default_nettype none
module ddc_properties (
  input wire logic        hclk,       // clock
  input wire logic        hresetn,    // async reset, active low
  input wire logic        reg_wr,     // write strobe
  input wire logic [7:0]  reg_addr,   // register offset
  input wire logic [15:0] reg_wdata,  // write data
  input wire logic [15:0] reg_rdata,  // readback
  input wire logic        soft_reset, // register hold
  input wire logic        sclk_out,   // divided sample clock
  input wire logic        sclk_oe,    // clock pin enable
  input wire logic        sclk_pin    // resolved pin level
);
  // ==========================================================
  // properties, all in the hclk domain
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_rsvd;
    reg_addr == 8'h01 |-> !reg_rdata[15] && !reg_rdata[10];
  endproperty
  property p_write;
    reg_wr && reg_addr == 8'h01 && !soft_reset |=>
      reg_rdata == ($past(reg_wdata) & ddc_pkg::DDC_CTRL_WMASK);
  endproperty
  property p_hold;
    !reg_wr && !soft_reset && reg_addr == 8'h01 |=> $stable(reg_rdata);
  endproperty
  // soft reset must win even over a write in the same cycle
  property p_srst;
    soft_reset |=> reg_rdata == ddc_pkg::DDC_CTRL_RESET;
  endproperty
  property p_oe;
    reg_addr == 8'h01 |-> sclk_oe == reg_rdata[8];
  endproperty
  property p_pin_off;
    !sclk_oe |-> !sclk_pin;
  endproperty
  property p_pin_on;
    sclk_oe |-> sclk_pin == sclk_out;
  endproperty
  property p_sclk;
    $changed(sclk_out) |=> $stable(sclk_out) [*3] ##1 $changed(sclk_out);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  a_write: assert property (p_write) else $error("write lost");
  a_hold: assert property (p_hold) else $error("register drift");
  a_srst: assert property (p_srst) else $error("soft reset lost");
  a_oe: assert property (p_oe) else $error("enable mismatch");
  a_pin_off: assert property (p_pin_off) else $error("pin active");
  a_pin_on: assert property (p_pin_on) else $error("pin dead");
  a_sclk: assert property (p_sclk) else $error("clock period");
  c_write: cover property (reg_wr && reg_addr == 8'h01);
  c_srst: cover property (soft_reset ##1 !soft_reset);
  c_off: cover property (!sclk_oe [*4]);
endmodule
`default_nettype wire

// ---- pkg/ddc_link_if.sv ----
// Purpose: pins between baseband source and converter control block
// Assumes: both ends clocked by the same hclk in the bench
// Notes:   sample clock pin level resolved here from its enable
`timescale 1ns/10ps
`default_nettype none
interface ddc_link_if;
  logic        reg_wr;        // one-cycle register write strobe
  logic [7:0]  reg_addr;      // register offset
  logic [15:0] reg_wdata;     // write data
  logic [15:0] reg_rdata;     // read data for reg_addr
  logic        soft_reset;    // level, holds register at reset value
  logic        sclk_out;      // divided sample clock from device
  logic        sclk_oe;       // device drives the clock pin
  wire         sclk_pin;      // resolved pin level
  logic [15:0] first_sample_port;
  logic [15:0] second_sample_port;
  logic        transmit_gate_pin;

  // undriven pin reads low
  assign sclk_pin = sclk_oe ? sclk_out : 1'b0;

  modport device (
    input  reg_wr, reg_addr, reg_wdata, soft_reset,
    output reg_rdata, sclk_out, sclk_oe,
    input  first_sample_port, second_sample_port, transmit_gate_pin
  );
  modport host (
    output reg_wr, reg_addr, reg_wdata, soft_reset,
    input  reg_rdata, sclk_pin,
    output first_sample_port, second_sample_port, transmit_gate_pin
  );
endinterface
`default_nettype wire

// ---- pkg/ddc_pkg.sv ----
// Purpose: shared constants for the datapath control link, both ends
// Assumes: one hclk at 200 MHz drives both ends
// Notes:   device register map, field positions, host register map
package ddc_pkg;
  // ==========================================================
  // device register map
  localparam logic [7:0]  DDC_CTRL_OFS      = 8'h01;
  localparam logic [15:0] DDC_CTRL_RESET    = 16'h0100;
  localparam logic [15:0] DDC_CTRL_WMASK    = 16'h7BFF;
  localparam int          DDC_ACC_CLR_BIT   = 14;
  localparam int          DDC_PN_ON_BIT     = 13;
  localparam int          DDC_SYNC_SEL_BIT  = 12;
  localparam int          DDC_PULSE_ON_BIT  = 11;
  localparam int          DDC_ISINC_BIT     = 9;
  localparam int          DDC_CLK_OE_BIT    = 8;
  localparam int          DDC_INTERP_HI     = 7;
  localparam int          DDC_INTERP_LO     = 6;
  localparam int          DDC_FMT_BIT       = 5;
  localparam int          DDC_SINGLE_BIT    = 4;
  localparam int          DDC_REAL_BIT      = 3;
  localparam int          DDC_SWAP_BIT      = 2;
  localparam int          DDC_QFIRST_BIT    = 1;
  localparam int          DDC_HALFGAIN_BIT  = 0;
  // ==========================================================
  // sample clock: half period in hclk cycles
  localparam real         DDC_HCLK_NS       = 5.0;
  localparam real         DDC_SCLK_HALF_NS  = 20.0;
  localparam logic [3:0]  DDC_SCLK_HALF_CYC =
    4'($rtoi(DDC_SCLK_HALF_NS / DDC_HCLK_NS));
  // ==========================================================
  // host register map (byte addresses)
  localparam logic [7:0]  DDC_H_CTRL_OFS    = 8'h00;
  localparam logic [7:0]  DDC_H_IWORD_OFS   = 8'h04;
  localparam logic [7:0]  DDC_H_QWORD_OFS   = 8'h08;
  localparam logic [7:0]  DDC_H_DEVREG_OFS  = 8'h0C;
  localparam logic [7:0]  DDC_H_STATUS_OFS  = 8'h10;
  localparam int          DDC_H_STREAM_BIT  = 0;
  localparam int          DDC_H_SINGLE_BIT  = 1;
  localparam int          DDC_H_SWAP_BIT    = 2;
  localparam int          DDC_H_SRST_BIT    = 3;
endpackage

// ---- src/ddc_device.sv ----
// Purpose: converter end: control register, sample clock, data assembler
// Assumes: pins from the source are asynchronous, two flops each
// Notes:   filter, oscillator and sync internals sit downstream
// Behaviour
// - control register two bytes, bits 15,10 reserved
// - bit 14 holds phase accumulator cleared
// - bit 13 enables pseudo-random alignment mode
// - bit 12 selects pulse or pseudo-random method
// - bit 11 enables pulse alignment mode
// - bit 9 routes samples through inverse sinc
// - bit 8 drives sample clock pin
// - bits 7:6 interpolation 1x 2x 4x 8x
// - bit 5 selects two's complement or offset binary
// - dual port: I first port, Q second
// - single port: interleaved words, half pair rate
// - bit 3 gives real-only output
// - gate pin marks I or Q, bit 2 swaps
// - bit 1 clear pairs I with next Q
// - bit 1 set pairs I with previous Q
// - bit 0 halves oscillator into modulator
// - soft reset holds register at power-up value
`timescale 1ns/10ps
`default_nettype none
module ddc_device (
  input  wire logic        hclk,            // 200 MHz clock
  input  wire logic        hresetn,         // async reset, active low
  ddc_link_if.device       link,            // pins to the source
  output logic             out_valid,       // one-cycle pair strobe
  output logic [15:0]      out_i,           // assembled I, two's compl.
  output logic [15:0]      out_q,           // assembled Q, two's compl.
  output logic             nco_accum_clear, // hold accumulator in reset
  output logic             pseudorandom_align_on, // pn alignment on
  output logic             align_method_pn, // 1 pn, 0 pulse method
  output logic             pulse_align_on,  // pulse alignment on
  output logic             inv_sinc_on,     // inverse sinc in path
  output logic [1:0]       interp_rate,     // 0:1x 1:2x 2:4x 3:8x
  output logic             real_only,       // q path after modulator off
  output logic             mod_half_gain    // oscillator scaled by 0.5
);

  // ==========================================================
  // offset binary to two's complement: flip the sign bit
  function automatic logic [15:0] to_twos(input logic [15:0] w,
                                          input logic        ofs);
    to_twos = ofs ? {~w[15], w[14:0]} : w;
  endfunction

  // ==========================================================
  // control register
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;

  // soft reset wins over a write in the same cycle
  always_comb begin
    next_ctrl = ctrl;
    if (link.soft_reset) begin
      next_ctrl = ddc_pkg::DDC_CTRL_RESET;
    end else if (link.reg_wr &&
                 link.reg_addr == ddc_pkg::DDC_CTRL_OFS) begin
      next_ctrl = link.reg_wdata & ddc_pkg::DDC_CTRL_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= ddc_pkg::DDC_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // unmapped offsets read zero
  assign link.reg_rdata = (link.reg_addr == ddc_pkg::DDC_CTRL_OFS) ?
                          ctrl : 16'h0000;

  // mode outputs straight from the register bits
  assign nco_accum_clear       = ctrl[ddc_pkg::DDC_ACC_CLR_BIT];
  assign pseudorandom_align_on = ctrl[ddc_pkg::DDC_PN_ON_BIT];
  assign align_method_pn       = ctrl[ddc_pkg::DDC_SYNC_SEL_BIT];
  assign pulse_align_on        = ctrl[ddc_pkg::DDC_PULSE_ON_BIT];
  assign inv_sinc_on           = ctrl[ddc_pkg::DDC_ISINC_BIT];
  assign interp_rate = ctrl[ddc_pkg::DDC_INTERP_HI:
                            ddc_pkg::DDC_INTERP_LO];
  assign real_only             = ctrl[ddc_pkg::DDC_REAL_BIT];
  assign mod_half_gain         = ctrl[ddc_pkg::DDC_HALFGAIN_BIT];

  // ==========================================================
  // sample clock divider
  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic       sclk;
  logic       next_sclk;
  logic       sclk_rise;

  // free running so the assembler keeps its cadence when the pin is off
  always_comb begin
    next_div_cnt = div_cnt + 4'h1;
    next_sclk    = sclk;
    sclk_rise    = 1'b0;
    if (div_cnt == ddc_pkg::DDC_SCLK_HALF_CYC - 4'h1) begin
      next_div_cnt = 4'h0;
      next_sclk    = ~sclk;
      sclk_rise    = ~sclk;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 4'h0;
      sclk    <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      sclk    <= next_sclk;
    end
  end

  assign link.sclk_out = sclk;
  assign link.sclk_oe  = ctrl[ddc_pkg::DDC_CLK_OE_BIT];

  // ==========================================================
  // pin synchroniser: gate, second port, first port
  logic [32:0] pin_s1;
  logic [32:0] pin_s2;

  // stage one feeds stage two only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 33'h0_0000_0000;
      pin_s2 <= 33'h0_0000_0000;
    end else begin
      pin_s1 <= {link.transmit_gate_pin, link.second_sample_port,
                 link.first_sample_port};
      pin_s2 <= pin_s1;
    end
  end

  logic [15:0] p1_w;
  logic [15:0] p2_w;
  logic        word_is_i;
  logic        ofs_fmt;
  assign p1_w    = to_twos(pin_s2[15:0], ofs_fmt);
  assign p2_w    = to_twos(pin_s2[31:16], ofs_fmt);
  assign ofs_fmt = ctrl[ddc_pkg::DDC_FMT_BIT];
  // gate high means I unless the polarity swap is set
  assign word_is_i = pin_s2[32] ^ ctrl[ddc_pkg::DDC_SWAP_BIT];

  // ==========================================================
  // data assembler, sampled at each rising sample clock
  logic [15:0] i_hold;
  logic [15:0] q_hold;
  logic        q_seen;
  logic [15:0] next_i_hold;
  logic [15:0] next_q_hold;
  logic        next_q_seen;
  logic        next_valid;
  logic [15:0] next_out_i;
  logic [15:0] next_out_q;

  always_comb begin
    next_i_hold = i_hold;
    next_q_hold = q_hold;
    next_q_seen = q_seen;
    next_valid  = 1'b0;
    next_out_i  = out_i;
    next_out_q  = out_q;
    if (sclk_rise) begin
      if (!ctrl[ddc_pkg::DDC_SINGLE_BIT]) begin
        next_valid = 1'b1;
        next_out_i = p1_w;
        next_out_q = p2_w;
      end else if (!ctrl[ddc_pkg::DDC_QFIRST_BIT]) begin
        // one word per edge, two edges per pair
        if (word_is_i) begin
          next_i_hold = p1_w;
        end else begin
          next_valid = 1'b1;
          next_out_i = i_hold;
          next_out_q = p1_w;
        end
      end else begin
        // first I before any Q has nothing to pair with
        if (!word_is_i) begin
          next_q_hold = p1_w;
          next_q_seen = 1'b1;
        end else if (q_seen) begin
          next_valid = 1'b1;
          next_out_i = p1_w;
          next_out_q = q_hold;
        end
      end
      // only a new pair touches out_q, so it stands until the next one
      if (real_only && next_valid) begin
        next_out_q = 16'h0000;
      end
    end
    if (!ctrl[ddc_pkg::DDC_SINGLE_BIT] || !ctrl[ddc_pkg::DDC_QFIRST_BIT]) begin
      next_q_seen = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      i_hold    <= 16'h0000;
      q_hold    <= 16'h0000;
      q_seen    <= 1'b0;
      out_valid <= 1'b0;
      out_i     <= 16'h0000;
      out_q     <= 16'h0000;
    end else begin
      i_hold    <= next_i_hold;
      q_hold    <= next_q_hold;
      q_seen    <= next_q_seen;
      out_valid <= next_valid;
      out_i     <= next_out_i;
      out_q     <= next_out_q;
    end
  end

endmodule
`default_nettype wire

// ---- src/ddc_host.sv ----
// Purpose: baseband source end: AHB-Lite registers, sample port driver
// Assumes: sample clock pin is asynchronous, sampled by two flops
// Notes:   zero wait states, response always OKAY
`timescale 1ns/10ps
`default_nettype none
module ddc_host (
  input  wire logic        hclk,       // 200 MHz clock
  input  wire logic        hresetn,    // async reset, active low
  input  wire logic        hsel,       // slave select
  input  wire logic [31:0] haddr,      // byte address
  input  wire logic [1:0]  htrans,     // transfer type
  input  wire logic        hwrite,     // write when high
  input  wire logic [2:0]  hsize,      // word only
  input  wire logic [31:0] hwdata,     // write data
  input  wire logic        hready,     // bus ready
  output logic             hreadyout,  // always ready
  output logic             hresp,      // always OKAY
  output logic [31:0]      hrdata,     // read data
  ddc_link_if.host         link        // pins to the converter
);

  // ==========================================================
  // bus address phase capture
  logic       dp_act;
  logic       dp_wr;
  logic [7:0] dp_addr;
  logic       next_dp_act;
  logic       next_dp_wr;
  logic [7:0] next_dp_addr;

  always_comb begin
    next_dp_act  = hsel && htrans[1] && hready;
    next_dp_wr   = hwrite;
    next_dp_addr = haddr[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_act  <= 1'b0;
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_act  <= next_dp_act;
      dp_wr   <= next_dp_wr;
      dp_addr <= next_dp_addr;
    end
  end

  logic wr_en;
  assign wr_en     = dp_act && dp_wr;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================
  // link clock sync and edge find; s1 feeds s2 only
  logic sclk_s1;
  logic sclk_s2;
  logic sclk_s3;
  logic rise;
  assign rise = sclk_s2 && !sclk_s3;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
    end else begin
      sclk_s1 <= link.sclk_pin;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
    end
  end

  // ==========================================================
  // host registers and sample driver
  logic [3:0]  ctrl;
  logic [15:0] i_word;
  logic [15:0] q_word;
  logic [15:0] pairs;
  logic        q_phase;
  logic [15:0] p1;
  logic [15:0] p2;
  logic        gate;
  logic [3:0]  next_ctrl;
  logic [15:0] next_i_word;
  logic [15:0] next_q_word;
  logic [15:0] next_pairs;
  logic        next_q_phase;
  logic [15:0] next_p1;
  logic [15:0] next_p2;
  logic        next_gate;

  // words change just after a seen rise, well clear of the next one
  always_comb begin
    next_ctrl    = ctrl;
    next_i_word  = i_word;
    next_q_word  = q_word;
    next_pairs   = pairs;
    next_q_phase = q_phase;
    next_p1      = p1;
    next_p2      = p2;
    next_gate    = gate;
    if (wr_en && dp_addr == ddc_pkg::DDC_H_CTRL_OFS) begin
      next_ctrl = hwdata[3:0];
    end
    if (wr_en && dp_addr == ddc_pkg::DDC_H_IWORD_OFS) begin
      next_i_word = hwdata[15:0];
    end
    if (wr_en && dp_addr == ddc_pkg::DDC_H_QWORD_OFS) begin
      next_q_word = hwdata[15:0];
    end
    if (rise && ctrl[ddc_pkg::DDC_H_STREAM_BIT]) begin
      if (!ctrl[ddc_pkg::DDC_H_SINGLE_BIT]) begin
        next_p1      = i_word;
        next_p2      = q_word;
        next_gate    = 1'b1;
        next_q_phase = 1'b0;
        next_pairs   = pairs + 16'h0001;
      end else begin
        // I then Q on the first port, gate marks which
        next_p1      = q_phase ? q_word : i_word;
        next_gate    = ~q_phase ^ ctrl[ddc_pkg::DDC_H_SWAP_BIT];
        next_q_phase = ~q_phase;
        if (q_phase) begin
          next_pairs = pairs + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl    <= 4'h0;
      i_word  <= 16'h0000;
      q_word  <= 16'h0000;
      pairs   <= 16'h0000;
      q_phase <= 1'b0;
      p1      <= 16'h0000;
      p2      <= 16'h0000;
      gate    <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      i_word  <= next_i_word;
      q_word  <= next_q_word;
      pairs   <= next_pairs;
      q_phase <= next_q_phase;
      p1      <= next_p1;
      p2      <= next_p2;
      gate    <= next_gate;
    end
  end

  // sample format is whatever software loads
  assign link.first_sample_port  = p1;
  assign link.second_sample_port = p2;
  assign link.transmit_gate_pin  = gate;
  assign link.soft_reset         = ctrl[ddc_pkg::DDC_H_SRST_BIT];

  // device register write passes through in the data phase
  assign link.reg_wr    = wr_en && dp_addr == ddc_pkg::DDC_H_DEVREG_OFS;
  assign link.reg_addr  = ddc_pkg::DDC_CTRL_OFS;
  assign link.reg_wdata = hwdata[15:0];

  // ==========================================================
  // read mux, unmapped reads zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_act && !dp_wr) begin
      unique case (dp_addr)
        ddc_pkg::DDC_H_CTRL_OFS:   hrdata = {28'h0, ctrl};
        ddc_pkg::DDC_H_IWORD_OFS:  hrdata = {16'h0, i_word};
        ddc_pkg::DDC_H_QWORD_OFS:  hrdata = {16'h0, q_word};
        ddc_pkg::DDC_H_DEVREG_OFS: hrdata = {16'h0, link.reg_rdata};
        ddc_pkg::DDC_H_STATUS_OFS: hrdata = {pairs, 15'h0, sclk_s2};
        default:                   hrdata = 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire
